// ---- src/arsq_pkg.sv ----
// Package: register map, field layout, timing and channel codes of the sequencer
package arsq_pkg;

    // Timing: 200 MHz core clock, 2.0 MHz converter clock, 32.768 kHz time base
    localparam int unsigned CLK_HZ     = 200_000_000;
    localparam int unsigned BASE_HZ    = 2_000_000;
    localparam int unsigned TB_HZ      = 32_768;
    localparam int unsigned BASE_DIV   = CLK_HZ / BASE_HZ;
    localparam int unsigned TB_STEP    = TB_HZ / 8;
    localparam int unsigned TB_MOD     = BASE_HZ / 8;
    localparam int unsigned PASS_US    = 15_625;
    localparam int unsigned PASS_TICKS = PASS_US * TB_HZ / 1_000_000;
    localparam int unsigned ENTRIES    = 32;
    localparam int unsigned SLOT_TICKS = PASS_TICKS / ENTRIES;

    // Sleep time per select code, in ms
    localparam int unsigned SLEEP_MS [8] = '{0, 1, 2, 4, 8, 16, 24, 27};

    // Byte offsets of the registers
    localparam logic [11:0] OFS_CTRL     = 12'h000;
    localparam logic [11:0] OFS_IRQ      = 12'h004;
    localparam logic [11:0] OFS_IRQ_MASK = 12'h008;
    localparam logic [11:0] OFS_TOP      = 12'h00c;
    localparam logic [11:0] OFS_TOP_MASK = 12'h010;
    localparam logic [11:0] OFS_GAIN_LO  = 12'h014;
    localparam logic [11:0] OFS_GAIN_HI  = 12'h018;
    localparam logic [11:0] OFS_OPTION   = 12'h01c;
    localparam logic [11:0] OFS_STAT     = 12'h020;
    localparam logic [4:0]  TBL_SEL      = 5'h01;
    localparam logic [4:0]  RES_SEL      = 5'h02;

    // Field positions
    localparam int unsigned CTRL_EN_BIT    = 0;
    localparam int unsigned CTRL_START_BIT = 1;
    localparam int unsigned CTRL_SLP_LSB   = 2;
    localparam int unsigned ROUND_BIT      = 0;
    localparam int unsigned TOP_ROUND_BIT  = 1;
    localparam int unsigned OPT_WEIGHT_BIT = 0;
    localparam int unsigned OPT_APP_BIT    = 1;
    localparam int unsigned OPT_CHGI_BIT   = 2;
    localparam int unsigned OPT_BKUP_BIT   = 3;
    localparam int unsigned OPT_PACK_BIT   = 4;

    // Reset values
    localparam logic [7:0]  TBL_RST = 8'h1f;
    localparam logic [5:0]  GAIN_RST = 6'h00;
    localparam logic [4:0]  OPT_RST  = 5'h00;

    // Channel codes
    localparam logic [4:0] CH_TEMP     = 5'h00;
    localparam logic [4:0] CH_LOAD_LO  = 5'h01;
    localparam logic [4:0] CH_LOAD_HI  = 5'h05;
    localparam logic [4:0] CH_VBAT     = 5'h06;
    localparam logic [4:0] CH_IBAT     = 5'h07;
    localparam logic [4:0] CH_CHGIN    = 5'h08;
    localparam logic [4:0] CH_GP_FIRST = 5'h0a;
    localparam logic [4:0] CH_GP_LAST  = 5'h15;
    localparam logic [4:0] CH_APP      = 5'h16;
    localparam logic [4:0] CH_CHGI     = 5'h18;
    localparam logic [4:0] CH_BKUP     = 5'h19;
    localparam logic [4:0] CH_PACK     = 5'h1a;
    localparam logic [4:0] STOP_CODE   = 5'h1f;
    localparam int unsigned GP_PER_REG = 6;

    typedef enum logic [2:0] {ST_IDLE, ST_FETCH, ST_WAIT_SLOT, ST_CONV, ST_DONE, ST_SLEEP} arsq_state_e;

    // Sleep length in time-base ticks, rounded down
    function automatic logic [9:0] sleep_ticks(input logic [2:0] sel);
        sleep_ticks = 10'(SLEEP_MS[sel] * TB_HZ / 1000);
    endfunction

endpackage

// ---- src/arsq_mem_if.sv ----
// Interface: write and read port of the result store
`timescale 1ns/1ps
interface arsq_mem_if #(
    parameter int unsigned WIDTH = 11,
    parameter int unsigned DEPTH = 32
);
    logic                     wr_en;
    logic [$clog2(DEPTH)-1:0] wr_addr;
    logic [WIDTH-1:0]         wr_data;
    logic [$clog2(DEPTH)-1:0] rd_addr;
    logic [WIDTH-1:0]         rd_data;

    modport owner (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport store (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// ---- src/arsq_result_mem.sv ----
// Result store: one write port, registered read port
`timescale 1ns/1ps
module arsq_result_mem #(
    parameter int unsigned WIDTH = 11,
    parameter int unsigned DEPTH = 32
) (
    input  wire logic   core_clk_i,
    input  wire logic   rst_b_i,
    arsq_mem_if.store   m
);
    logic [WIDTH-1:0] mem [DEPTH];

    // Array holds no reset; contents are valid only after a pass
    always_ff @(posedge core_clk_i) begin
        if (m.wr_en) begin
            mem[m.wr_addr] <= m.wr_data;
        end
    end

    // Read data from a flop; a same-cycle write returns the old word
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            m.rd_data <= '0;
        end else begin
            m.rd_data <= mem[m.rd_addr];
        end
    end
endmodule

// ---- src/arsq_sequencer.sv ----
// Round-robin converter sequencer with table, result store and APB registers
//
// The implementer's own choices: register access over APB and the register offsets.
`timescale 1ns/1ps
//
// How it works
// - Optional channels 22, 24, 25, 26 convert only with their enable set.
// - Thirty-two table entries, five selector bits each, name the input.
// - Thirty-two result entries of eleven bits: value plus gain bit.
// - Start bit makes the block walk the table in order.
// - Upper three entry bits drive bias controls, lower five pick channel.
// - Result goes to matching entry with gain bit as MSB.
// - Channel code 0x1F ends the pass without converting.
// - Stop sets round-done flag bit 0; its mask suppresses the interrupt.
// - Stop sets top bit 1 and the interrupt pin unless masked.
// - After a pass, sleep 0 to 27 ms by select field, then repeat.
// - New results overwrite old ones with no overflow flag.
// - A full pass of 32 results finishes within 15.625 ms.
// - Weight select bit picks LSB weighting; resets to 0, native.
// - Channel 0 carries die temperature.
// - Channels 1 to 5 carry regulator load currents.
// - Channel 6 carries battery voltage, full code at 4.8 V.
// - Battery voltage and current sampled together, converted in turn.
// - Battery current result is two's complement, positive for outflow.
// - Channel 8 carries scaled charger input voltage.
// - Twelve general inputs take gain bits from two gain registers.
// - Gain 0 is unity, 2.0 V range; gain 1 is ten, 200 mV.
// - A 32.768 kHz time base comes from the 2.0 MHz clock.
module arsq_sequencer (
    input  wire logic        core_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic             conv_req_o,
    output logic      [4:0]  conv_chan_o,
    output logic      [2:0]  conv_bias_o,
    output logic             conv_gain_o,
    output logic             pair_hold_o,
    input  wire logic        conv_done_i,
    input  wire logic [9:0]  conv_data_i,
    output logic             weight_select_o,
    output logic             app_supply_chan_en_o,
    output logic             charge_current_chan_en_o,
    output logic             backup_cell_chan_en_o,
    output logic             pack_detect_chan_en_o,
    output logic             chip_irq_out_o
);
    import arsq_pkg::*;

    arsq_state_e state;
    arsq_state_e next_state;
    logic [4:0]  idx;
    logic [4:0]  next_idx;
    logic        conv_enable;
    logic        conv_start;
    logic [2:0]  sleep_time_sel;
    logic        round_done_flag;
    logic        round_done_mask;
    logic        top_flag;
    logic        top_mask;
    logic [5:0]  gain_ctrl_low;
    logic [5:0]  gain_ctrl_high;
    logic [4:0]  conv_option_reg;
    logic [7:0]  tbl [ENTRIES];
    logic [6:0]  base_cnt;
    logic [17:0] tb_acc;
    logic        tb_tick;
    logic [3:0]  slot_cnt;
    logic        slot_free;
    logic [9:0]  sleep_cnt;
    logic [31:0] reg_rd;
    logic        sel_res;

    arsq_mem_if #(.WIDTH(11), .DEPTH(ENTRIES)) res_if ();

    // Gain bit of a general input, from low or high gain register
    function automatic logic gain_of(input logic [4:0] ch, input logic [5:0] lo, input logic [5:0] hi);
        logic [4:0] k;
        k = ch - CH_GP_FIRST;
        if (ch < CH_GP_FIRST || ch > CH_GP_LAST) begin
            gain_of = 1'b0;
        end else if (k < 5'(GP_PER_REG)) begin
            gain_of = lo[k[2:0]];
        end else begin
            gain_of = hi[3'(k - 5'(GP_PER_REG))];
        end
    endfunction

    // Optional channels are live only when enabled
    function automatic logic chan_live(input logic [4:0] ch, input logic [4:0] opt);
        case (ch)
            CH_APP:  chan_live = opt[OPT_APP_BIT];
            CH_CHGI: chan_live = opt[OPT_CHGI_BIT];
            CH_BKUP: chan_live = opt[OPT_BKUP_BIT];
            CH_PACK: chan_live = opt[OPT_PACK_BIT];
            default: chan_live = 1'b1;
        endcase
    endfunction

    // Mapped word addresses
    function automatic logic reg_hit(input logic [11:0] a);
        reg_hit = (a[1:0] == 2'b00) && (a[11:7] == TBL_SEL || a[11:7] == RES_SEL || a <= OFS_STAT);
    endfunction

    // Time base: 2.0 MHz enable, then fractional step to 32.768 kHz
    wire        base_wrap = (base_cnt == 7'(BASE_DIV - 1));
    wire [17:0] tb_sum    = tb_acc + 18'(TB_STEP);
    wire        tb_wrap   = (tb_sum >= 18'(TB_MOD));
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            base_cnt <= '0;
            tb_acc   <= '0;
            tb_tick  <= 1'b0;
        end else begin
            base_cnt <= base_wrap ? 7'h00 : base_cnt + 7'h01;
            tb_tick  <= base_wrap & tb_wrap;
            if (base_wrap) begin
                tb_acc <= tb_wrap ? tb_sum - 18'(TB_MOD) : tb_sum;
            end
        end
    end

    // APB decode; the slave never inserts wait states
    wire       apb_wr   = psel_i & penable_i & pwrite_i;
    wire       apb_set  = psel_i & ~penable_i;
    wire       is_tbl   = (paddr_i[11:7] == TBL_SEL) && (paddr_i[1:0] == 2'b00);
    wire       is_res   = (paddr_i[11:7] == RES_SEL) && (paddr_i[1:0] == 2'b00);
    wire [4:0] widx     = paddr_i[6:2];
    wire       wr_ctrl  = apb_wr & (paddr_i == OFS_CTRL);
    wire       wr_irq   = apb_wr & (paddr_i == OFS_IRQ);
    wire       wr_top   = apb_wr & (paddr_i == OFS_TOP);
    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i & penable_i & ~reg_hit(paddr_i);

    // Sequencer view of the current entry
    wire [7:0] entry     = tbl[idx];
    wire [4:0] ent_chan  = entry[4:0];
    wire [2:0] ent_bias  = entry[7:5];
    wire       run       = conv_enable & conv_start;
    wire       at_stop   = (ent_chan == STOP_CODE);
    wire       ent_live  = chan_live(ent_chan, conv_option_reg);
    wire       last      = (idx == 5'(ENTRIES - 1));
    wire       conv_fin  = (state == ST_CONV) & conv_done_i;
    wire       skip_wr   = (state == ST_FETCH) & ~at_stop & ~ent_live;
    wire       round_evt = (state == ST_DONE);
    wire       pass_start = ((state == ST_IDLE) & run) | ((state == ST_SLEEP) & (sleep_cnt == 10'h000) & run);
    wire       slot_tick = tb_tick & (slot_cnt == 4'(SLOT_TICKS - 1));
    wire       stat_busy = (state != ST_IDLE);
    wire       stat_slp  = (state == ST_SLEEP);

    // Conversion request waits for a free slot, so a pass fits its budget
    assign conv_req_o = (state == ST_WAIT_SLOT) & slot_free & run;

    // Result write: conversion data with gain bit, or zero for a skipped entry
    assign res_if.wr_en   = conv_fin | skip_wr;
    assign res_if.wr_addr = idx;
    assign res_if.wr_data = conv_fin ? {conv_gain_o, conv_data_i} : 11'h000;
    assign res_if.rd_addr = widx;

    // Next state of the walk through the table
    always_comb begin
        next_state = state;
        next_idx   = idx;
        case (state)
            ST_IDLE: begin
                if (run) begin
                    next_state = ST_FETCH;
                    next_idx   = 5'h00;
                end
            end
            ST_FETCH: begin
                if (at_stop) begin
                    next_state = ST_DONE;
                end else if (!ent_live) begin
                    if (last) begin
                        next_state = ST_DONE;
                    end else begin
                        next_idx = idx + 5'h01;
                    end
                end else begin
                    next_state = ST_WAIT_SLOT;
                end
            end
            ST_WAIT_SLOT: begin
                if (slot_free) begin
                    next_state = ST_CONV;
                end
            end
            ST_CONV: begin
                if (conv_done_i) begin
                    if (last) begin
                        next_state = ST_DONE;
                    end else begin
                        next_state = ST_FETCH;
                        next_idx   = idx + 5'h01;
                    end
                end
            end
            ST_DONE: begin
                next_state = ST_SLEEP;
            end
            ST_SLEEP: begin
                if (sleep_cnt == 10'h000) begin
                    next_state = ST_FETCH;
                    next_idx   = 5'h00;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        if (!run) begin
            next_state = ST_IDLE;
        end
    end

    // State, slot and sleep counters
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state     <= ST_IDLE;
            idx       <= '0;
            slot_cnt  <= '0;
            slot_free <= 1'b0;
            sleep_cnt <= '0;
        end else begin
            state     <= next_state;
            idx       <= next_idx;
            slot_cnt  <= pass_start ? 4'h0 : slot_cnt + {3'h0, tb_tick};
            slot_free <= pass_start | slot_tick | (slot_free & ~conv_req_o);
            if (round_evt) begin
                sleep_cnt <= sleep_ticks(sleep_time_sel);
            end else if (stat_slp & tb_tick & (sleep_cnt != 10'h000)) begin
                sleep_cnt <= sleep_cnt - 10'h001;
            end
        end
    end

    // Converter selection latched when an entry is accepted
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            conv_chan_o <= '0;
            conv_bias_o <= '0;
            conv_gain_o <= 1'b0;
            pair_hold_o <= 1'b0;
        end else if ((state == ST_FETCH) & ~at_stop & ent_live) begin
            conv_chan_o <= ent_chan;
            conv_bias_o <= ent_bias;
            conv_gain_o <= gain_of(ent_chan, gain_ctrl_low, gain_ctrl_high);
            // Battery pair shares one sample instant; current follows voltage
            if (ent_chan == CH_VBAT) begin
                pair_hold_o <= 1'b1;
            end else if (ent_chan != CH_IBAT) begin
                pair_hold_o <= 1'b0;
            end
        end
    end

    // Control registers; hardware set wins over a software clear
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            conv_enable     <= 1'b0;
            conv_start      <= 1'b0;
            sleep_time_sel  <= '0;
            round_done_flag <= 1'b0;
            round_done_mask <= 1'b0;
            top_flag        <= 1'b0;
            top_mask        <= 1'b0;
            gain_ctrl_low   <= GAIN_RST;
            gain_ctrl_high  <= GAIN_RST;
            conv_option_reg <= OPT_RST;
        end else begin
            if (wr_ctrl) begin
                conv_enable    <= pwdata_i[CTRL_EN_BIT];
                conv_start     <= pwdata_i[CTRL_START_BIT];
                sleep_time_sel <= pwdata_i[CTRL_SLP_LSB +: 3];
            end
            round_done_flag <= round_evt | (round_done_flag & ~(wr_irq & pwdata_i[ROUND_BIT]));
            top_flag <= (round_evt & ~round_done_mask) | (top_flag & ~(wr_top & pwdata_i[TOP_ROUND_BIT]));
            if (apb_wr & (paddr_i == OFS_IRQ_MASK)) begin
                round_done_mask <= pwdata_i[ROUND_BIT];
            end
            if (apb_wr & (paddr_i == OFS_TOP_MASK)) begin
                top_mask <= pwdata_i[TOP_ROUND_BIT];
            end
            if (apb_wr & (paddr_i == OFS_GAIN_LO)) begin
                gain_ctrl_low <= pwdata_i[5:0];
            end
            if (apb_wr & (paddr_i == OFS_GAIN_HI)) begin
                gain_ctrl_high <= pwdata_i[5:0];
            end
            if (apb_wr & (paddr_i == OFS_OPTION)) begin
                conv_option_reg <= pwdata_i[4:0];
            end
        end
    end

    // Sequence table, one byte per entry
    for (genvar g = 0; g < ENTRIES; g++) begin : g_tbl
        always_ff @(posedge core_clk_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                tbl[g] <= TBL_RST;
            end else if (apb_wr & is_tbl & (widx == 5'(g))) begin
                tbl[g] <= pwdata_i[7:0];
            end
        end
    end

    // Result store; its read flop is loaded in the setup cycle
    arsq_result_mem #(.WIDTH(11), .DEPTH(ENTRIES)) u_res (
        .core_clk_i (core_clk_i),
        .rst_b_i    (rst_b_i),
        .m          (res_if.store)
    );

    // Read selection; unmapped words read as zero
    wire [31:0] reg_mux =
        (paddr_i == OFS_CTRL)     ? {27'h0, sleep_time_sel, conv_start, conv_enable} :
        (paddr_i == OFS_IRQ)      ? {31'h0, round_done_flag} :
        (paddr_i == OFS_IRQ_MASK) ? {31'h0, round_done_mask} :
        (paddr_i == OFS_TOP)      ? {30'h0, top_flag, 1'b0} :
        (paddr_i == OFS_TOP_MASK) ? {30'h0, top_mask, 1'b0} :
        (paddr_i == OFS_GAIN_LO)  ? {26'h0, gain_ctrl_low} :
        (paddr_i == OFS_GAIN_HI)  ? {26'h0, gain_ctrl_high} :
        (paddr_i == OFS_OPTION)   ? {27'h0, conv_option_reg} :
        (paddr_i == OFS_STAT)     ? {25'h0, stat_slp, stat_busy, idx} :
        is_tbl                    ? {24'h0, tbl[widx]} : 32'h0;

    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            reg_rd  <= '0;
            sel_res <= 1'b0;
        end else if (apb_set) begin
            reg_rd  <= reg_mux;
            sel_res <= is_res;
        end
    end

    assign prdata_o = sel_res ? {21'h0, res_if.rd_data} : reg_rd;

    // Loose bits to the analog side
    assign weight_select_o          = conv_option_reg[OPT_WEIGHT_BIT];
    assign app_supply_chan_en_o     = conv_option_reg[OPT_APP_BIT];
    assign charge_current_chan_en_o = conv_option_reg[OPT_CHGI_BIT];
    assign backup_cell_chan_en_o    = conv_option_reg[OPT_BKUP_BIT];
    assign pack_detect_chan_en_o    = conv_option_reg[OPT_PACK_BIT];
    assign chip_irq_out_o           = top_flag & ~top_mask;

    // Helper: time-base ticks spent in the current pass
    logic [9:0] pass_ticks;
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pass_ticks <= '0;
        end else if (pass_start | ~stat_busy | stat_slp) begin
            pass_ticks <= '0;
        end else begin
            pass_ticks <= pass_ticks + {9'h0, tb_tick};
        end
    end

    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_b_i);

    a_round_flag_set: assert property (round_evt |=> round_done_flag)
        else $error("round-done flag not set after stop");
    a_irq_out_path: assert property (round_evt && !round_done_mask && !top_mask |=> ##0 chip_irq_out_o)
        else $error("interrupt pin not raised at end of pass");
    a_stop_no_conv: assert property ((state == ST_FETCH) && at_stop && run |=> state == ST_DONE && !conv_req_o)
        else $error("stop entry did not end the pass");
    a_result_write: assert property (conv_fin |-> res_if.wr_en && res_if.wr_addr == idx
                                     && res_if.wr_data == {conv_gain_o, conv_data_i})
        else $error("result not written to its entry");
    a_opt_chan_gate: assert property (conv_req_o |-> chan_live(conv_chan_o, conv_option_reg))
        else $error("disabled optional channel converted");
    a_disabled_idle: assert property (!conv_enable |=> state == ST_IDLE ##1 !conv_req_o)
        else $error("sequencer active while disabled");
    a_last_entry: assert property (conv_fin && last && run |=> state == ST_DONE)
        else $error("entry 31 did not close the pass");
    a_sleep_restart: assert property ((state == ST_SLEEP) && sleep_cnt == 10'h000 && run
                                      |=> state == ST_FETCH && idx == 5'h00)
        else $error("sequence did not restart at entry 0");
    a_tick_spacing: assert property (tb_tick |=> !tb_tick [*8])
        else $error("time base ticks too close");
    a_pass_budget: assert property (pass_ticks <= 10'(PASS_TICKS))
        else $error("pass exceeded its time budget");
    a_bias_drive: assert property ((state == ST_FETCH) && !at_stop && ent_live && run
                                   |=> conv_bias_o == $past(ent_bias) && conv_chan_o == $past(ent_chan))
        else $error("bias or channel not taken from entry");
endmodule

// ---- verif/arsq_conv_model.sv ----
// Converter model: answers each request after a random delay
`timescale 1ns/1ps
module arsq_conv_model (
    input  wire logic       core_clk_i,
    input  wire logic       req_i,
    input  wire logic [4:0] chan_i,
    input  wire logic [2:0] bias_i,
    output logic            done_o,
    output logic      [9:0] data_o
);
    logic [9:0] val;
    initial begin
        done_o = 1'b0;
        data_o = 10'h155;
    end
    // Idle data line shows the inverse, so a stale code never matches
    always @(posedge core_clk_i) begin
        if (req_i === 1'b1) begin
            val = {chan_i, bias_i, 2'b10};
            repeat ($urandom_range(8, 1)) @(posedge core_clk_i);
            done_o <= 1'b1;
            data_o <= val;
            @(posedge core_clk_i);
            done_o <= 1'b0;
            data_o <= ~val;
        end
    end
endmodule

// ---- verif/arsq_sequencer_tb.sv ----
// Bench: one-entry passes with random entries, gains, options and masks
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin fails++; $display("[ERR] %0t got %h want %h", $time, a, e); end end
module arsq_sequencer_tb;
    import arsq_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, r, g;
    logic        pready, pslverr, req, gain, done, irq, err, seen_g, pair, seen_p;
    logic [4:0]  chan, seen_c;
    wire  [4:0]  opto;
    logic [2:0]  bias, seen_b, s;
    logic [9:0]  data;
    logic [7:0]  e;
    logic [10:0] x;
    int          fails = 0, compares = 0, reqs = 0, n, k;
    always #2.5 core_clk = ~core_clk;
    // Record every conversion request and what stood with it
    always @(posedge core_clk) if (req === 1'b1) begin
        reqs++;
        seen_c = chan;
        seen_b = bias;
        seen_g = gain;
        seen_p = pair;
    end
    arsq_sequencer dut (.core_clk_i(core_clk), .rst_b_i(rst_b), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .conv_req_o(req), .conv_chan_o(chan), .conv_bias_o(bias), .conv_gain_o(gain),
        .pair_hold_o(pair), .conv_done_i(done), .conv_data_i(data), .weight_select_o(opto[0]),
        .app_supply_chan_en_o(opto[1]), .charge_current_chan_en_o(opto[2]),
        .backup_cell_chan_en_o(opto[3]), .pack_detect_chan_en_o(opto[4]), .chip_irq_out_o(irq));
    arsq_conv_model conv (.core_clk_i(core_clk), .req_i(req), .chan_i(chan), .bias_i(bias),
        .done_o(done), .data_o(data));
    // Expected result word; gain bits for ch 10..21 sit contiguously in cfg
    function automatic logic [10:0] exp_res(input logic [7:0] ent, input logic [31:0] cfg);
        int   ch;
        logic gn;
        ch = ent[4:0];
        gn = (ch >= 10 && ch <= 21) ? cfg[ch-10] : 1'b0;
        if ((ch == 22 && !cfg[13]) || (ch == 24 && !cfg[14]) || (ch == 25 && !cfg[15]) ||
            (ch == 26 && !cfg[16]) || ch == 31) return 11'h000;
        return {gn, ent[4:0], ent[7:5], 2'b10};
    endfunction
    task automatic conclude;
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // One APB transfer; read data and error taken at the pready edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin fails++; conclude(); end
        r = prdata;
        err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    initial begin
        void'($urandom(32'h7f74));
        repeat (6) @(posedge core_clk);
        rst_b <= 1'b1;
        apb(0, OFS_OPTION, 0);
        `CHK(r[4:0], OPT_RST)
        apb(0, 12'h080, 0);
        `CHK(r[7:0], TBL_RST)
        apb(0, 12'h200, 0);
        `CHK(err, 1'b1)
        for (int t = 0; t < 24; t++) begin
            e = (t == 0) ? 8'h1f : (t == 1) ? 8'hb6 : (t == 2) ? 8'h35 : 8'($urandom);
            if (t > 2 && e[4:0] == STOP_CODE) e[4:0] = CH_VBAT;
            g = $urandom;
            s = g[21:19];
            x = exp_res(e, g);
            apb(1, OFS_GAIN_LO, {26'h0, g[5:0]});
            apb(1, OFS_GAIN_HI, {26'h0, g[11:6]});
            apb(1, OFS_OPTION, {27'h0, g[16:12]});
            apb(1, OFS_IRQ_MASK, {31'h0, g[17]});
            apb(1, OFS_TOP_MASK, {30'h0, g[18], 1'b0});
            apb(1, 12'h080, {24'h0, e});
            reqs = 0;
            apb(1, OFS_CTRL, {27'h0, s, 2'b11});
            k = 0;
            do begin apb(0, OFS_IRQ, 0); k++; end while (r[0] !== 1'b1 && k < 40);
            `CHK(r[0], 1'b1)
            `CHK(irq, !(g[17] | g[18]))
            `CHK(opto, g[16:12])
            `CHK(reqs != 0, x != 0)
            if (x != 0) begin
                `CHK(seen_c, e[4:0])
                `CHK(seen_b, e[7:5])
                `CHK(seen_g, x[10])
                if (e[4:0] != CH_IBAT) `CHK(seen_p, e[4:0] == CH_VBAT)
            end
            // A nonzero sleep holds the block asleep at the stop entry
            if (s != 0) begin
                apb(0, OFS_STAT, 0);
                `CHK(r[6:0], {2'b11, (t == 0) ? 5'h00 : 5'h01})
            end
            apb(1, OFS_CTRL, 0);
            // Let the disabling edge pass before counting requests
            @(posedge core_clk);
            reqs = 0;
            repeat (20) @(posedge core_clk);
            `CHK(reqs, 0)
            apb(0, 12'h100, 0);
            if (e[4:0] != STOP_CODE) `CHK(r[10:0], x)
            apb(1, OFS_IRQ, 32'h1);
            apb(1, OFS_TOP, 32'h2);
        end
        conclude();
    end
endmodule
